//--- gfm_board_model.sv
// Board logic that drives the mux pin inputs
`timescale 1ns/1ps
module gfm_board_model (
  input wire logic clk_sys,
  input wire logic [5:0] want_lvl,
  output logic [5:0] gpio_in
);
  initial gpio_in = 6'h00;
  // board raises loss
  // Registered driver: levels move only after an edge
  always @(posedge clk_sys) begin
    gpio_in <= want_lvl;
  end
endmodule : gfm_board_model

//--- gfm_params.svh
// Offsets, field positions, reset values and timing counts of the pin mux
// ==========================================================================
// Contract
// - Each pin's role comes from the code in its configuration register.
// - Code 0x20 ORs the pin into the timing-error clear enable.
// - Codes 0x44..0x47 OR the pin into clock stops C1, C0, D1, D0.
// - Codes 0x60/62/64/66 OR the pin into differential enables 0..3.
// - Codes 0x70/72 OR the pin into CMOS output enables 0 and 1.
// - Code 0x80 drives the pin high while the host interrupt is up.
// - Codes 0x88/0x90 show a reference silent for the last second.
// - Codes 0x89/0x91 show the single-cycle period monitor failure.
// - Codes 0x8A/0x92 show the coarse frequency monitor failure.
// - Codes 0x8B/0x93 show the guard soak timer indicator.
// - Codes 0x8C/0x94 show the masked OR of all reference failures.
// - Code 0xA8 shows the DPLL neither in holdover nor free-run.
// - Code 0xA9 shows the DPLL in holdover.
// - Code 0xAB shows the selected reference, low 0 and high 1.
// - Code 0xB0 shows phase error below 1us for a whole 1s.
// - Code 0xB1 shows phase error below 10us for a whole 1s.
// - Code 0xB2 shows phase error below 10us for a whole 10s.
// - Code 0x00 leaves the pin a plain input with no function.
// - Codes 0x10/0x14 make the pin a loss-of-signal input per reference.
`ifndef GFM_PARAMS_SVH
`define GFM_PARAMS_SVH

// ==========================================================================
// Function codes
`define GFM_CODE_DEFAULT 8'h00
`define GFM_CODE_LOS0 8'h10
`define GFM_CODE_LOS1 8'h14
`define GFM_CODE_TIE_CLR 8'h20
`define GFM_CODE_STOP_C1 8'h44
`define GFM_CODE_STOP_C0 8'h45
`define GFM_CODE_STOP_D1 8'h46
`define GFM_CODE_STOP_D0 8'h47
`define GFM_CODE_DIFF0 8'h60
`define GFM_CODE_DIFF1 8'h62
`define GFM_CODE_DIFF2 8'h64
`define GFM_CODE_DIFF3 8'h66
`define GFM_CODE_CMOS0 8'h70
`define GFM_CODE_CMOS1 8'h72
`define GFM_CODE_IRQ 8'h80
`define GFM_CODE_NOSIG0 8'h88
`define GFM_CODE_SCM0 8'h89
`define GFM_CODE_CFM0 8'h8A
`define GFM_CODE_GST0 8'h8B
`define GFM_CODE_FAIL0 8'h8C
`define GFM_CODE_NOSIG1 8'h90
`define GFM_CODE_SCM1 8'h91
`define GFM_CODE_CFM1 8'h92
`define GFM_CODE_GST1 8'h93
`define GFM_CODE_FAIL1 8'h94
`define GFM_CODE_NORMAL 8'hA8
`define GFM_CODE_HOLDOVER 8'hA9
`define GFM_CODE_REFSEL 8'hAB
`define GFM_CODE_LOCK1 8'hB0
`define GFM_CODE_LOCK2 8'hB1
`define GFM_CODE_LOCK3 8'hB2

// ==========================================================================
// Register byte offsets and fields
`define GFM_OFS_DPLL_CTRL 8'h20
`define GFM_OFS_CLK_STOP 8'h24
`define GFM_OFS_DIFF_EN 8'h28
`define GFM_OFS_CMOS_EN 8'h2C
`define GFM_OFS_FAIL_MASK 8'h30
`define GFM_OFS_EFF_CTL 8'h34
`define GFM_OFS_PIN_STAT 8'h38
`define GFM_MASK_LOS 0
`define GFM_MASK_SCM 1
`define GFM_MASK_CFM 2
`define GFM_MASK_GST 3
`define GFM_MASK_STRIDE 4

// ==========================================================================
// Reset values
`define GFM_RST_CFG 8'h00
`define GFM_RST_DPLL_CTRL 1'h0
`define GFM_RST_CLK_STOP 4'h0
`define GFM_RST_DIFF_EN 4'h0
`define GFM_RST_CMOS_EN 2'h0
`define GFM_RST_FAIL_MASK 8'hFF

// ==========================================================================
// Timing
`define GFM_CLK_PERIOD_NS 10
`define GFM_NS_PER_MS 1000000
`define GFM_ONE_SEC_MS 1000
`define GFM_TEN_SEC_MS 10000
`define GFM_MS_TO_CYC(ms) ((ms) * (`GFM_NS_PER_MS / `GFM_CLK_PERIOD_NS))

`endif

//--- gfm_pin_cell.sv
// One pin's function decoder: control contribution and status selection
`timescale 1ns/1ps
`include "gfm_params.svh"
module gfm_pin_cell import gfm_pkg::*; (
  input logic [7:0] cfg_code,
  input logic pin_level,
  input gfm_stat_t stat,
  output gfm_ctl_t ctl,
  output logic drv_level,
  output logic drv_en
);

  // ==========================================================================
  // Code hits
  gfm_ctl_t ctl_hit;
  gfm_stat_t stat_hit;

  assign ctl_hit.tie_clr = cfg_code == `GFM_CODE_TIE_CLR;
  assign ctl_hit.clk_stop[3] = cfg_code == `GFM_CODE_STOP_C1;
  assign ctl_hit.clk_stop[2] = cfg_code == `GFM_CODE_STOP_C0;
  assign ctl_hit.clk_stop[1] = cfg_code == `GFM_CODE_STOP_D1;
  assign ctl_hit.clk_stop[0] = cfg_code == `GFM_CODE_STOP_D0;
  assign ctl_hit.diff_en[0] = cfg_code == `GFM_CODE_DIFF0;
  assign ctl_hit.diff_en[1] = cfg_code == `GFM_CODE_DIFF1;
  assign ctl_hit.diff_en[2] = cfg_code == `GFM_CODE_DIFF2;
  assign ctl_hit.diff_en[3] = cfg_code == `GFM_CODE_DIFF3;
  assign ctl_hit.cmos_en[0] = cfg_code == `GFM_CODE_CMOS0;
  assign ctl_hit.cmos_en[1] = cfg_code == `GFM_CODE_CMOS1;
  assign ctl_hit.loss_of_signal_input[0] = cfg_code == `GFM_CODE_LOS0;
  assign ctl_hit.loss_of_signal_input[1] = cfg_code == `GFM_CODE_LOS1;

  assign stat_hit.irq = cfg_code == `GFM_CODE_IRQ;
  assign stat_hit.no_sig = {cfg_code == `GFM_CODE_NOSIG1,
                            cfg_code == `GFM_CODE_NOSIG0};
  assign stat_hit.single_cycle_period_monitor = {cfg_code == `GFM_CODE_SCM1,
                         cfg_code == `GFM_CODE_SCM0};
  assign stat_hit.coarse_frequency_monitor = {cfg_code == `GFM_CODE_CFM1,
                         cfg_code == `GFM_CODE_CFM0};
  assign stat_hit.guard_soak_timer = {cfg_code == `GFM_CODE_GST1,
                         cfg_code == `GFM_CODE_GST0};
  assign stat_hit.fail = {cfg_code == `GFM_CODE_FAIL1,
                          cfg_code == `GFM_CODE_FAIL0};
  assign stat_hit.normal = cfg_code == `GFM_CODE_NORMAL;
  assign stat_hit.holdover = cfg_code == `GFM_CODE_HOLDOVER;
  assign stat_hit.ref_sel = cfg_code == `GFM_CODE_REFSEL;
  assign stat_hit.lock = {cfg_code == `GFM_CODE_LOCK3,
                          cfg_code == `GFM_CODE_LOCK2,
                          cfg_code == `GFM_CODE_LOCK1};

  // ==========================================================================
  // Outputs: one-hot hits, so an AND-OR picks the single selected item
  // no hit leaves an input with no effect
  assign ctl = ctl_hit & {$bits(gfm_ctl_t){pin_level}};
  assign drv_level = |(stat_hit & stat);
  // drive whenever a status code is held
  assign drv_en = |stat_hit;

endmodule : gfm_pin_cell

//--- gfm_pkg.sv
// Types shared by the pin mux modules
package gfm_pkg;

  // ==========================================================================
  // Pin contribution to internal control bits
  typedef struct packed {
    logic tie_clr;
    logic [3:0] clk_stop; // [3]=C bit1 [2]=C bit0 [1]=D bit1 [0]=D bit0
    logic [3:0] diff_en;
    logic [1:0] cmos_en;
    logic [1:0] loss_of_signal_input;
  } gfm_ctl_t;

  // ==========================================================================
  // Internal flags a status pin may present
  typedef struct packed {
    logic irq;
    logic [1:0] no_sig;
    logic [1:0] single_cycle_period_monitor;
    logic [1:0] coarse_frequency_monitor;
    logic [1:0] guard_soak_timer;
    logic [1:0] fail;
    logic normal;
    logic holdover;
    logic ref_sel;
    logic [2:0] lock; // [0]=1us/1s [1]=10us/1s [2]=10us/10s
  } gfm_stat_t;

endpackage : gfm_pkg

//--- gfm_top.sv
// GPIO function multiplexer with AXI4-Lite configuration registers
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "gfm_params.svh"
module gfm_top import gfm_pkg::*; #(
  parameter int NUM_PINS = 6,
  parameter int unsigned ONE_SEC_CYC = `GFM_MS_TO_CYC(`GFM_ONE_SEC_MS),
  parameter int unsigned TEN_SEC_CYC = `GFM_MS_TO_CYC(`GFM_TEN_SEC_MS)
) (
  input logic clk_sys,
  input logic sys_rst,
  // AXI4-Lite slave
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Pins
  input logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  // Flags from the clock core
  input logic host_irq,
  input logic [1:0] ref_edge,
  input logic [1:0] scm_fail,
  input logic [1:0] cfm_fail,
  input logic [1:0] gst_ind,
  input logic dpll_holdover,
  input logic dpll_freerun,
  input logic dpll_ref_sel,
  input logic phase_lt_1us,
  input logic phase_lt_10us,
  // Effective controls to the clock core
  output logic tie_clr_en,
  output logic [3:0] clk_stop,
  output logic [3:0] diff_oe,
  output logic [1:0] cmos_oe,
  output logic [1:0] ext_los
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_TMR = 5;

  // ==========================================================================
  // Register storage
  logic [7:0] cfg_q [NUM_PINS];
  logic dpll_ctrl_q;
  logic [3:0] clk_stop_q;
  logic [3:0] diff_en_q;
  logic [1:0] cmos_en_q;
  logic [7:0] fail_mask_q;

  // ==========================================================================
  // AXI4-Lite write channel: address and data latched independently
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire wr_lane0 = w_strb_q[0];

  // Each channel stalls once its beat is held, until the response drains
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write address decode
  wire wr_is_pin = (aw_addr_q[7:5] == 3'h0) && (aw_addr_q[1:0] == 2'h0) &&
                   (int'(aw_addr_q[4:2]) < NUM_PINS);
  wire wr_dpll = aw_addr_q == `GFM_OFS_DPLL_CTRL;
  wire wr_stop = aw_addr_q == `GFM_OFS_CLK_STOP;
  wire wr_diff = aw_addr_q == `GFM_OFS_DIFF_EN;
  wire wr_cmos = aw_addr_q == `GFM_OFS_CMOS_EN;
  wire wr_mask = aw_addr_q == `GFM_OFS_FAIL_MASK;
  // Read-only words accept a write with OKAY and keep their value
  wire wr_ro = (aw_addr_q == `GFM_OFS_EFF_CTL) ||
               (aw_addr_q == `GFM_OFS_PIN_STAT);
  wire wr_mapped = wr_is_pin | wr_dpll | wr_stop | wr_diff | wr_cmos |
                   wr_mask | wr_ro;
  wire wr_en = wr_fire & wr_lane0;

  // Address beat capture
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  // Data beat capture
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  // Response follows the write by one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Global control registers; all fields live in byte lane 0
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dpll_ctrl_q <= `GFM_RST_DPLL_CTRL;
      clk_stop_q <= `GFM_RST_CLK_STOP;
      diff_en_q <= `GFM_RST_DIFF_EN;
      cmos_en_q <= `GFM_RST_CMOS_EN;
      fail_mask_q <= `GFM_RST_FAIL_MASK;
    end else if (wr_en) begin
      if (wr_dpll) dpll_ctrl_q <= w_data_q[0];
      if (wr_stop) clk_stop_q <= w_data_q[3:0];
      if (wr_diff) diff_en_q <= w_data_q[3:0];
      if (wr_cmos) cmos_en_q <= w_data_q[1:0];
      if (wr_mask) fail_mask_q <= w_data_q[7:0];
    end
  end

  // ==========================================================================
  // Observation timers: 0,1 reference silence; 2..4 lock windows
  logic [NUM_TMR-1:0] tmr_clr;
  logic [NUM_TMR-1:0] tmr_done;
  // an edge restarts the silence count
  assign tmr_clr[1:0] = ref_edge;
  // a phase excursion restarts the window
  assign tmr_clr[2] = ~phase_lt_1us;
  assign tmr_clr[3] = ~phase_lt_10us;
  assign tmr_clr[4] = ~phase_lt_10us;

  genvar t;
  generate
    for (t = 0; t < NUM_TMR; t++) begin : g_tmr
      // The last timer spans ten seconds, the rest one second
      localparam int unsigned WIN = (t == NUM_TMR - 1) ? TEN_SEC_CYC
                                                       : ONE_SEC_CYC;
      logic [31:0] cnt_q;
      // Saturates at the window so the flag holds while calm persists
      always_ff @(posedge clk_sys) begin
        if (sys_rst || tmr_clr[t]) begin
          cnt_q <= 32'h0000_0000;
        end else if (cnt_q != 32'(WIN)) begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
      end
      assign tmr_done[t] = cnt_q == 32'(WIN);
    end
  endgenerate

  // ==========================================================================
  // Per-pin configuration registers and decoders
  gfm_ctl_t pin_ctl [NUM_PINS];
  gfm_ctl_t ctl_acc [NUM_PINS+1];
  logic [NUM_PINS-1:0] pin_drv;
  logic [NUM_PINS-1:0] pin_en;
  gfm_stat_t stat_w;

  assign ctl_acc[0] = '0;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      wire hit = wr_is_pin && (int'(aw_addr_q[4:2]) == p);
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_q[p] <= `GFM_RST_CFG;
        end else if (wr_en && hit) begin
          cfg_q[p] <= w_data_q[7:0];
        end
      end

      gfm_pin_cell u_cell (
        .cfg_code (cfg_q[p]),
        .pin_level (gpio_in[p]),
        .stat (stat_w),
        .ctl (pin_ctl[p]),
        .drv_level (pin_drv[p]),
        .drv_en (pin_en[p])
      );

      // Several pins may share one function; their levels are OR-ed
      assign ctl_acc[p+1] = ctl_acc[p] | pin_ctl[p];
    end
  endgenerate

  wire gfm_ctl_t pins_ctl = ctl_acc[NUM_PINS];

  // ==========================================================================
  // Status flags offered to the pins
  logic [1:0] fail_w;
  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_fail
      localparam int B = r * `GFM_MASK_STRIDE;
      // masked failure OR, mask bit 1 counts the source
      assign fail_w[r] =
        (pins_ctl.loss_of_signal_input[r] & fail_mask_q[B + `GFM_MASK_LOS]) |
        (scm_fail[r] & fail_mask_q[B + `GFM_MASK_SCM]) |
        (cfm_fail[r] & fail_mask_q[B + `GFM_MASK_CFM]) |
        (gst_ind[r] & fail_mask_q[B + `GFM_MASK_GST]);
    end
  endgenerate

  assign stat_w.irq = host_irq;
  assign stat_w.no_sig = tmr_done[1:0];
  assign stat_w.single_cycle_period_monitor = scm_fail;
  assign stat_w.coarse_frequency_monitor = cfm_fail;
  assign stat_w.guard_soak_timer = gst_ind;
  assign stat_w.fail = fail_w;
  // normal means neither holdover nor free-run
  assign stat_w.normal = ~dpll_holdover & ~dpll_freerun;
  assign stat_w.holdover = dpll_holdover;
  // low for reference 0, high for reference 1
  assign stat_w.ref_sel = dpll_ref_sel;
  assign stat_w.lock = tmr_done[4:2];

  // ==========================================================================
  // Effective controls: register bit OR pin level
  // tie clear combine
  wire eff_tie = dpll_ctrl_q | pins_ctl.tie_clr;
  wire [3:0] eff_stop = clk_stop_q | pins_ctl.clk_stop;
  wire [3:0] eff_diff = diff_en_q | pins_ctl.diff_en;
  wire [1:0] eff_cmos = cmos_en_q | pins_ctl.cmos_en;

  // Registered so the core sees glitch-free levels, one cycle late
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tie_clr_en <= 1'b0;
      clk_stop <= 4'h0;
      diff_oe <= 4'h0;
      cmos_oe <= 2'h0;
      ext_los <= 2'h0;
    end else begin
      tie_clr_en <= eff_tie;
      clk_stop <= eff_stop;
      diff_oe <= eff_diff;
      cmos_oe <= eff_cmos;
      ext_los <= pins_ctl.loss_of_signal_input;
    end
  end

  // status pins registered, one cycle behind their flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gpio_out <= '0;
      gpio_oe <= '0;
    end else begin
      gpio_out <= pin_drv & pin_en;
      gpio_oe <= pin_en;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read address decode
  wire [2:0] rd_idx = s_axi_araddr[4:2];
  wire rd_is_pin = (s_axi_araddr[7:5] == 3'h0) &&
                   (s_axi_araddr[1:0] == 2'h0) &&
                   (int'(rd_idx) < NUM_PINS);
  wire rd_dpll = s_axi_araddr == `GFM_OFS_DPLL_CTRL;
  wire rd_stop = s_axi_araddr == `GFM_OFS_CLK_STOP;
  wire rd_diff = s_axi_araddr == `GFM_OFS_DIFF_EN;
  wire rd_cmos = s_axi_araddr == `GFM_OFS_CMOS_EN;
  wire rd_mask = s_axi_araddr == `GFM_OFS_FAIL_MASK;
  wire rd_eff = s_axi_araddr == `GFM_OFS_EFF_CTL;
  wire rd_stat = s_axi_araddr == `GFM_OFS_PIN_STAT;
  wire rd_mapped = rd_is_pin | rd_dpll | rd_stop | rd_diff | rd_cmos |
                   rd_mask | rd_eff | rd_stat;

  // Pin word index is guarded so an unused slot never reads the array
  wire [7:0] rd_cfg = rd_is_pin ? cfg_q[rd_idx] : 8'h00;
  wire [12:0] eff_word = {eff_tie, eff_stop, eff_diff, eff_cmos,
                          pins_ctl.loss_of_signal_input};
  wire [15:0] stat_word = {8'(gpio_oe), 8'(gpio_in)};

  // Read data select; unused bits read as zero
  wire [31:0] rd_word =
    rd_is_pin ? {24'h000000, rd_cfg} :
    rd_dpll ? {31'h0000_0000, dpll_ctrl_q} :
    rd_stop ? {28'h000_0000, clk_stop_q} :
    rd_diff ? {28'h000_0000, diff_en_q} :
    rd_cmos ? {30'h0000_0000, cmos_en_q} :
    rd_mask ? {24'h000000, fail_mask_q} :
    rd_eff ? {19'h0_0000, eff_word} :
    rd_stat ? {16'h0000, stat_word} : 32'h0000_0000;

  // Answer one cycle after the address is taken
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : gfm_top

//--- gfm_top_monitor.sv
// Port-level concurrent checks for the pin function mux
`timescale 1ns/1ps
module gfm_top_monitor #(
  parameter int NUM_PINS = 6
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [1:0] ext_los
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic any_in_q;

  // ========================================================================
  // Helper: any pin high last edge, since loss flags come only from pins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) any_in_q <= 1'b0;
    else any_in_q <= |gpio_in;
  end

  // ========================================================================
  // Register bus sequencing
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write answer late");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("write accepted while answering");
  property p_wr_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("write answer not released");
  property p_rd_ans;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("read accepted while answering");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read answer not released");

  // ========================================================================
  // Pin side
  property p_oe_out;
    (gpio_out & ~gpio_oe) == '0;
  endproperty
  a_oe_out: assert property (p_oe_out)
    else $error("pin high without drive enable");
  property p_los_cause;
    ext_los != 2'h0 |-> any_in_q;
  endproperty
  a_los_cause: assert property (p_los_cause)
    else $error("loss flag with no pin high");
  property p_los_drop;
    gpio_in == '0 |=> ext_los == 2'h0;
  endproperty
  a_los_drop: assert property (p_los_drop)
    else $error("loss flag stuck after pins fell");
endmodule : gfm_top_monitor

//--- test_gpio_function_mux.sv
// Self-checking bench for the pin function mux
`timescale 1ns/1ps
module test_gpio_function_mux;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q, r;
  logic [3:0] s_axi_wstrb = 4'hF, clk_stop, diff_oe;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tie_clr_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, cmos_oe, ext_los;
  logic [5:0] want = 6'h00, gpio_in, gpio_out, gpio_oe;
  logic host_irq = 1'b0, dpll_holdover = 1'b0, dpll_freerun = 1'b0;
  logic dpll_ref_sel = 1'b0, phase_lt_1us = 1'b0, phase_lt_10us = 1'b0;
  logic [1:0] ref_edge = 2'h0, scm_fail = 2'h0, cfm_fail = 2'h0;
  logic [1:0] gst_ind = 2'h0;
  logic [7:0] c, msk;
  int fail_count = 0, checks = 0, seed = 32'h7EC948D4;
  wire [12:0] ctl_now = {tie_clr_en, clk_stop, diff_oe, cmos_oe, ext_los};
  localparam logic [7:0] ctl_codes [16] = '{8'h00, 8'h10, 8'h14, 8'h20,
    8'h44, 8'h45, 8'h46, 8'h47, 8'h60, 8'h62, 8'h64, 8'h66, 8'h70, 8'h72,
    8'h21, 8'h61};
  localparam logic [7:0] st_codes [18] = '{8'h80, 8'h88, 8'h89, 8'h8A,
    8'h8B, 8'h8C, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'hA8, 8'hA9, 8'hAB,
    8'hB0, 8'hB1, 8'hB2, 8'h81};

  // ========================================================================
  // Clock, design and board; short timers keep the run brief
  always #5 clk_sys = ~clk_sys;
  gfm_top #(.NUM_PINS(6), .ONE_SEC_CYC(20), .TEN_SEC_CYC(50)) u_dut (.*);
  gfm_board_model u_board (.clk_sys, .want_lvl(want), .gpio_in);

  // ========================================================================
  // Reporting
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic hang;
    fail_count++;
    $display("ERROR %0t bus answer never came", $time);
    give_verdict();
  endtask : hang

  // ========================================================================
  // Bus master tasks: entered just after an edge, leave on an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
    if (n == 20) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_q = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
    if (n == 20) hang();
  endtask : rd

  // ========================================================================
  // Expected pin effects, worked out from the code tables
  function automatic logic [12:0] ctl_exp(input logic [7:0] k);
    case (k)
      8'h20: return 13'h1000;
      8'h44: return 13'h0800;
      8'h45: return 13'h0400;
      8'h46: return 13'h0200;
      8'h47: return 13'h0100;
      8'h60: return 13'h0010;
      8'h62: return 13'h0020;
      8'h64: return 13'h0040;
      8'h66: return 13'h0080;
      8'h70: return 13'h0004;
      8'h72: return 13'h0008;
      8'h10: return 13'h0001;
      8'h14: return 13'h0002;
      default: return 13'h0000;
    endcase
  endfunction : ctl_exp
  function automatic logic [1:0] st_exp(input logic [7:0] k);
    logic v;
    case (k)
      8'h80: v = host_irq;
      8'h88, 8'h90: v = 1'b1;
      8'h89, 8'h91: v = scm_fail[k[4]];
      8'h8A, 8'h92: v = cfm_fail[k[4]];
      8'h8B, 8'h93: v = gst_ind[k[4]];
      8'h8C: v = |({gst_ind[0], cfm_fail[0], scm_fail[0], want[0]} & msk[3:0]);
      8'h94: v = |({gst_ind[1], cfm_fail[1], scm_fail[1], want[2]} & msk[7:4]);
      8'hA8: v = !dpll_holdover && !dpll_freerun;
      8'hA9: v = dpll_holdover;
      8'hAB: v = dpll_ref_sel;
      8'hB0: v = phase_lt_1us;
      8'hB1, 8'hB2: v = phase_lt_10us;
      default: return 2'b00;
    endcase
    return {1'b1, v};
  endfunction : st_exp

  // ========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h00);
    chk_val(rd_q, 32'h0);
    rd(8'h30);
    chk_val(rd_q, 32'hFF);
    rd(8'hFC);
    chk_val(32'(resp), 32'h2);
    wr(8'hF0, 32'h1);
    chk_val(32'(resp), 32'h2);
    $display("test registers done");
    foreach (ctl_codes[i]) begin
      c = ctl_codes[i];
      wr(8'h00, 32'(c));
      want <= 6'h01;
      repeat (3) @(posedge clk_sys);
      chk_val(32'({gpio_oe[0], ctl_now}), 32'(ctl_exp(c)));
      want <= 6'h00;
      repeat (3) @(posedge clk_sys);
      chk_val(32'(ctl_now), 32'h0);
    end
    wr(8'h28, 32'h2);
    wr(8'h00, 32'h60);
    want <= 6'h01;
    repeat (3) @(posedge clk_sys);
    chk_val(32'(diff_oe), 32'h3);
    wr(8'h20, 32'h1);
    chk_val(32'(tie_clr_en), 32'h1);
    $display("test control codes done");
    r = $random(seed);
    msk = r[7:0];
    wr(8'h30, 32'(msk));
    wr(8'h00, 32'h10);
    wr(8'h08, 32'h14);
    foreach (st_codes[i]) begin
      c = st_codes[i];
      wr(8'h04, 32'(c));
      r = $random(seed);
      {host_irq, scm_fail, cfm_fail, gst_ind, dpll_holdover, dpll_freerun,
        dpll_ref_sel, phase_lt_1us} <= r[10:0];
      phase_lt_10us <= r[0] | r[11];
      want <= {3'h0, r[12], 1'b0, r[13]};
      repeat (60) @(posedge clk_sys);
      chk_val(32'({gpio_oe[1], gpio_out[1]}), 32'(st_exp(c)));
    end
    wr(8'h04, 32'h88);
    rd(8'h38);
    chk_val(32'(rd_q[15:8]), 32'h2);
    ref_edge <= 2'h1;
    @(posedge clk_sys);
    ref_edge <= 2'h0;
    repeat (3) @(posedge clk_sys);
    chk_val(32'(gpio_out[1]), 32'h0);
    repeat (25) @(posedge clk_sys);
    chk_val(32'(gpio_out[1]), 32'h1);
    $display("test status codes done");
    give_verdict();
  end
endmodule : test_gpio_function_mux

bind gfm_top gfm_top_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.*);
